// ### logic/mpc_pkg.sv
// constants for the multiport pin control block
package mpc_pkg;
    localparam int P0_W = 6;
    localparam int P1_W = 2;
    localparam int P2_W = 7;
    localparam int P3_W = 4;
    localparam int P5_W = 4;
    localparam int P6_W = 8;
    localparam int EDGE_W = 2;
    // port 2 bit positions
    localparam int P2_SCK = 0;
    localparam int P2_SO = 1;
    localparam int P2_SI = 2;
    localparam int P2_OD_LO = 3;
    localparam int P2_OD_HI = 4;
    localparam int P2_SS = 5;
    localparam int P2_TO = 6;
    // port 3 bit positions
    localparam int P3_TIN = 0;
    localparam int P3_TOB = 1;
    localparam int P3_TOW = 2;
    localparam int P3_TOC = 3;
    // pull-up capable mask of port 2
    localparam logic [6:0] P2_PU_MASK = 7'h67;
    localparam logic [6:0] P2_OD_MASK = 7'h18;
    // reset values
    localparam logic [7:0] RST_DIR_IN = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // edge select encodings
    typedef enum logic [1:0] {
        MPC_EDGE_NONE,
        MPC_EDGE_RISE,
        MPC_EDGE_FALL,
        MPC_EDGE_BOTH
    } mpc_edge_e;
endpackage

// ### logic/mpc_sync.sv
// three-stage pin synchroniser, per bit, with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mpc_sync #(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] val_ff;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else if (clk_en) begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a change only counts once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    val_ff[i] <= 1'b0;
                end else if (clk_en && (s2_ff[i] == s3_ff[i])) begin
                    val_ff[i] <= s2_ff[i];
                end
            end
        end
    endgenerate

    assign pin_sync = val_ff;
endmodule
`default_nettype wire

// ### logic/mpc_top.sv
// multiport pin control: direction, pull-ups, alternate functions
// Overview of operation
// - six-bit port zero, direction chosen per bit by its direction register
// - ports zero and one: pull-up only when input and shared select set
// - two-bit port one, direction chosen per bit by its direction register
// - seven-bit port two in port mode is general I/O, per-bit direction
// - port two bits 0,1,2,5,6 pull-ups follow their select, ignoring direction
// - port two bits 3 and 4 are open drain: drive low or release only
// - port two control mode carries timer a and both serial interfaces
// - four-bit port three in port mode is general I/O, per-bit direction
// - port three pull-ups follow their select regardless of direction
// - port three control mode carries timer b/c/wide, capture, buzzer, irqs
// - each external irq input detects rising, falling or both edges
// - four-bit open-drain port five, direction per bit by its register
// - eight-bit input-only port six; control mode routes analog inputs
// - low level on reset input is active reset
`timescale 1ns/1ps
`default_nettype none
module mpc_top
    import mpc_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // software side: direction 1 = input
    input  wire logic [mpc_pkg::P0_W-1:0] direction_reg_p0,
    input  wire logic [mpc_pkg::P1_W-1:0] direction_reg_p1,
    input  wire logic [mpc_pkg::P2_W-1:0] direction_reg_p2,
    input  wire logic [mpc_pkg::P3_W-1:0] direction_reg_p3,
    input  wire logic [mpc_pkg::P5_W-1:0] direction_reg_p5,
    input  wire logic [7:0]               pullup_sel_low_ports,
    input  wire logic [mpc_pkg::P2_W-1:0] pullup_sel_p2,
    input  wire logic [mpc_pkg::P3_W-1:0] pullup_sel_p3,
    input  wire logic [mpc_pkg::P2_W-1:0] ctrl_mode_p2,
    input  wire logic [mpc_pkg::P3_W-1:0] ctrl_mode_p3,
    input  wire logic                     ctrl_mode_p6,
    input  wire logic [7:0]               edge_sel,
    input  wire logic [mpc_pkg::P0_W-1:0] out_latch_p0,
    input  wire logic [mpc_pkg::P1_W-1:0] out_latch_p1,
    input  wire logic [mpc_pkg::P2_W-1:0] out_latch_p2,
    input  wire logic [mpc_pkg::P3_W-1:0] out_latch_p3,
    input  wire logic [mpc_pkg::P5_W-1:0] out_latch_p5,
    // peripheral side outputs into the pins
    input  wire logic                     timer_a_out,
    input  wire logic                     timer_b_out,
    input  wire logic                     timer_c_out,
    input  wire logic                     wide_timer_out,
    input  wire logic                     buzzer_out,
    input  wire logic                     buzzer_sel,
    input  wire logic                     sync_serial_out,
    input  wire logic                     async_tx,
    input  wire logic                     async_sel,
    input  wire logic                     sync_serial_clock_out,
    // pin side
    input  wire logic [mpc_pkg::P0_W-1:0] p0_in,
    output logic      [mpc_pkg::P0_W-1:0] p0_out,
    output logic      [mpc_pkg::P0_W-1:0] p0_oe,
    output logic      [mpc_pkg::P0_W-1:0] p0_pu,
    input  wire logic [mpc_pkg::P1_W-1:0] p1_in,
    output logic      [mpc_pkg::P1_W-1:0] p1_out,
    output logic      [mpc_pkg::P1_W-1:0] p1_oe,
    output logic      [mpc_pkg::P1_W-1:0] p1_pu,
    input  wire logic [mpc_pkg::P2_W-1:0] p2_in,
    output logic      [mpc_pkg::P2_W-1:0] p2_out,
    output logic      [mpc_pkg::P2_W-1:0] p2_oe,
    output logic      [mpc_pkg::P2_W-1:0] p2_pu,
    input  wire logic [mpc_pkg::P3_W-1:0] p3_in,
    output logic      [mpc_pkg::P3_W-1:0] p3_out,
    output logic      [mpc_pkg::P3_W-1:0] p3_oe,
    output logic      [mpc_pkg::P3_W-1:0] p3_pu,
    input  wire logic [mpc_pkg::P5_W-1:0] p5_in,
    output logic      [mpc_pkg::P5_W-1:0] p5_out,
    output logic      [mpc_pkg::P5_W-1:0] p5_oe,
    input  wire logic [mpc_pkg::P6_W-1:0] p6_in,
    // software-visible pin levels
    output logic      [mpc_pkg::P0_W-1:0] rd_p0,
    output logic      [mpc_pkg::P1_W-1:0] rd_p1,
    output logic      [mpc_pkg::P2_W-1:0] rd_p2,
    output logic      [mpc_pkg::P3_W-1:0] rd_p3,
    output logic      [mpc_pkg::P5_W-1:0] rd_p5,
    output logic      [mpc_pkg::P6_W-1:0] rd_p6,
    // peripheral side inputs from the pins
    output logic                          timer_a_clock_in,
    output logic                          timer_b_clock_in,
    output logic                          capture_edge_in,
    output logic                          sync_serial_in,
    output logic                          sync_serial_clock,
    output logic                          serial_chip_select,
    output logic                          async_rx,
    output logic                          async_clock_in,
    output logic      [3:0]               ext_irq_inputs,
    output logic                          analog_en,
    output logic      [7:0]               analog_inputs
);
    import mpc_pkg::*;

    localparam int ALL_W = P0_W + P1_W + P2_W + P3_W + P5_W + P6_W;

    logic [ALL_W-1:0] raw_all;
    logic [ALL_W-1:0] syn_all;
    logic [P0_W-1:0]  s0;
    logic [P1_W-1:0]  s1;
    logic [P2_W-1:0]  s2;
    logic [P3_W-1:0]  s3;
    logic [P5_W-1:0]  s5;
    logic [P6_W-1:0]  s6;
    logic [P3_W-1:0]  s3_prev_ff;
    logic [P2_W-1:0]  nxt_p2_out;
    logic [P2_W-1:0]  nxt_p2_oe;
    logic [P3_W-1:0]  nxt_p3_out;
    logic [P3_W-1:0]  nxt_p3_oe;
    logic [3:0]       nxt_irq;

    assign raw_all = {p6_in, p5_in, p3_in, p2_in, p1_in, p0_in};

    // pins come from outside the clock domain
    mpc_sync #(.W(ALL_W)) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .pin_in   (raw_all),
        .pin_sync (syn_all)
    );

    assign {s6, s5, s3, s2, s1, s0} = syn_all;

    // port two drivers; bits 3,4 never drive high
    always_comb begin
        nxt_p2_out = out_latch_p2;
        nxt_p2_oe  = ~direction_reg_p2;
        if (ctrl_mode_p2[P2_SO]) begin
            nxt_p2_out[P2_SO] = async_sel ? async_tx : sync_serial_out;
        end
        if (ctrl_mode_p2[P2_SCK]) begin
            nxt_p2_out[P2_SCK] = sync_serial_clock_out;
        end
        if (ctrl_mode_p2[P2_TO]) begin
            nxt_p2_out[P2_TO] = timer_a_out;
        end
        // direction still decides, software sets it per function
        nxt_p2_oe  = nxt_p2_oe & ~(P2_OD_MASK & nxt_p2_out);
        nxt_p2_out = nxt_p2_out & ~P2_OD_MASK;
    end

    always_comb begin
        nxt_p3_out = out_latch_p3;
        nxt_p3_oe  = ~direction_reg_p3;
        if (ctrl_mode_p3[P3_TOB]) begin
            nxt_p3_out[P3_TOB] = timer_b_out;
        end
        if (ctrl_mode_p3[P3_TOW]) begin
            nxt_p3_out[P3_TOW] = wide_timer_out;
        end
        if (ctrl_mode_p3[P3_TOC]) begin
            nxt_p3_out[P3_TOC] = buzzer_sel ? buzzer_out : timer_c_out;
        end
    end

    // driver and pull-up registers; reset leaves every pin an input
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            p0_out <= '0;
            p0_oe  <= '0;
            p0_pu  <= '0;
            p1_out <= '0;
            p1_oe  <= '0;
            p1_pu  <= '0;
            p2_out <= '0;
            p2_oe  <= '0;
            p2_pu  <= '0;
            p3_out <= '0;
            p3_oe  <= '0;
            p3_pu  <= '0;
            p5_out <= '0;
            p5_oe  <= '0;
        end else if (clk_en) begin
            p0_out <= out_latch_p0;
            p0_oe  <= ~direction_reg_p0;
            p0_pu  <= direction_reg_p0 & pullup_sel_low_ports[P0_W-1:0];
            p1_out <= out_latch_p1;
            p1_oe  <= ~direction_reg_p1;
            p1_pu  <= direction_reg_p1 & pullup_sel_low_ports[P0_W +: P1_W];
            p2_out <= nxt_p2_out;
            p2_oe  <= nxt_p2_oe;
            p2_pu  <= pullup_sel_p2 & P2_PU_MASK;
            p3_out <= nxt_p3_out;
            p3_oe  <= nxt_p3_oe;
            p3_pu  <= pullup_sel_p3;
            // open drain: only ever pulls low
            p5_out <= '0;
            p5_oe  <= ~direction_reg_p5 & ~out_latch_p5;
        end
    end

    // pin levels for software and peripherals
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_p0              <= '0;
            rd_p1              <= '0;
            rd_p2              <= '0;
            rd_p3              <= '0;
            rd_p5              <= '0;
            rd_p6              <= '0;
            timer_a_clock_in   <= 1'b0;
            timer_b_clock_in   <= 1'b0;
            capture_edge_in    <= 1'b0;
            sync_serial_in     <= 1'b0;
            sync_serial_clock  <= 1'b0;
            serial_chip_select <= 1'b0;
            async_rx           <= 1'b0;
            async_clock_in     <= 1'b0;
            analog_en          <= 1'b0;
            analog_inputs      <= '0;
        end else if (clk_en) begin
            rd_p0 <= s0;
            rd_p1 <= s1;
            rd_p2 <= s2;
            rd_p3 <= s3;
            rd_p5 <= s5;
            // analog mode masks the digital reading
            rd_p6 <= ctrl_mode_p6 ? RST_ZERO : s6;
            timer_a_clock_in   <= ctrl_mode_p2[P2_SS] & s2[P2_SS];
            serial_chip_select <= ctrl_mode_p2[P2_SS] & s2[P2_SS];
            sync_serial_in     <= ctrl_mode_p2[P2_SI] & s2[P2_SI];
            async_rx           <= ctrl_mode_p2[P2_SI] & s2[P2_SI];
            sync_serial_clock  <= ctrl_mode_p2[P2_SCK] & s2[P2_SCK];
            async_clock_in     <= ctrl_mode_p2[P2_SCK] & s2[P2_SCK];
            timer_b_clock_in   <= ctrl_mode_p3[P3_TIN] & s3[P3_TIN];
            capture_edge_in    <= ctrl_mode_p3[P3_TIN] & s3[P3_TIN];
            analog_en          <= ctrl_mode_p6;
            // digital copy only; true analog path is outside this block
            analog_inputs      <= ctrl_mode_p6 ? s6 : RST_ZERO;
        end
    end

    // edge detection on the four irq pins
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_irq
            always_comb begin
                case (mpc_edge_e'(edge_sel[k*EDGE_W +: EDGE_W]))
                    MPC_EDGE_RISE: nxt_irq[k] = s3[k] & ~s3_prev_ff[k];
                    MPC_EDGE_FALL: nxt_irq[k] = ~s3[k] & s3_prev_ff[k];
                    MPC_EDGE_BOTH: nxt_irq[k] = s3[k] ^ s3_prev_ff[k];
                    default:       nxt_irq[k] = 1'b0;
                endcase
                nxt_irq[k] = nxt_irq[k] & ctrl_mode_p3[k];
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s3_prev_ff     <= '0;
            ext_irq_inputs <= '0;
        end else if (clk_en) begin
            s3_prev_ff     <= s3;
            ext_irq_inputs <= nxt_irq;
        end
    end
endmodule
`default_nettype wire

// ### tb/mpc_monitor.sv
// port-level assertions for the multiport pin control block
`timescale 1ns/1ps
`default_nettype none
module mpc_monitor
    import mpc_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       clk_en,
    input wire logic [5:0] direction_reg_p0,
    input wire logic [6:0] direction_reg_p2,
    input wire logic [3:0] direction_reg_p3,
    input wire logic [3:0] direction_reg_p5,
    input wire logic [7:0] pullup_sel_low_ports,
    input wire logic [6:0] pullup_sel_p2,
    input wire logic [3:0] pullup_sel_p3,
    input wire logic [6:0] ctrl_mode_p2,
    input wire logic [3:0] ctrl_mode_p3,
    input wire logic       ctrl_mode_p6,
    input wire logic [3:0] out_latch_p5,
    input wire logic       timer_a_out,
    input wire logic [5:0] p0_oe,
    input wire logic [5:0] p0_pu,
    input wire logic [6:0] p2_out,
    input wire logic [6:0] p2_oe,
    input wire logic [6:0] p2_pu,
    input wire logic [3:0] p3_oe,
    input wire logic [3:0] p3_pu,
    input wire logic [3:0] p5_out,
    input wire logic [3:0] p5_oe,
    input wire logic [3:0] ext_irq_inputs,
    input wire logic [7:0] analog_inputs
);
    wire go = rst_n & clk_en;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_od_p2; ((p2_out | p2_pu) & P2_OD_MASK) == 7'h00; endproperty
    a_od_p2: assert property (p_od_p2) else $error("open-drain bit driven high");
    property p_pu_lo; go |=> p0_pu == $past(pullup_sel_low_ports[5:0] & direction_reg_p0); endproperty
    a_pu_lo: assert property (p_pu_lo) else $error("port0 pull-up wrong");
    property p_pu_hi;
        go |=> p2_pu == $past(pullup_sel_p2 & P2_PU_MASK) && p3_pu == $past(pullup_sel_p3);
    endproperty
    a_pu_hi: assert property (p_pu_hi) else $error("port2/3 pull-up wrong");
    property p_dir0; go |=> p0_oe == ~$past(direction_reg_p0); endproperty
    a_dir0: assert property (p_dir0) else $error("port0 direction wrong");
    property p_dir2; go |=> (p2_oe & ~P2_OD_MASK) == (~$past(direction_reg_p2) & ~P2_OD_MASK); endproperty
    a_dir2: assert property (p_dir2) else $error("port2 direction wrong");
    property p_dir3; go |=> (p3_oe | $past(ctrl_mode_p3)) == $past(~direction_reg_p3 | ctrl_mode_p3); endproperty
    a_dir3: assert property (p_dir3) else $error("port3 direction wrong");
    property p_p5; go |=> p5_out == 4'h0 && p5_oe == $past(~direction_reg_p5 & ~out_latch_p5); endproperty
    a_p5: assert property (p_p5) else $error("port5 open drain wrong");
    property p_tmr; go && ctrl_mode_p2[P2_TO] |=> p2_out[P2_TO] == $past(timer_a_out); endproperty
    a_tmr: assert property (p_tmr) else $error("timer output not on pin");
    property p_ana; go && !ctrl_mode_p6 |=> analog_inputs == 8'h00; endproperty
    a_ana: assert property (p_ana) else $error("analog inputs live in port mode");
    property p_irq; ext_irq_inputs[0] |=> !ext_irq_inputs[0]; endproperty
    a_irq: assert property (p_irq) else $error("irq pulse longer than a cycle");
    // reset must win even though the default disable would hide it
    property p_rst;
        disable iff (1'b0) !rst_n && clk_en |=> {p0_oe, p2_oe, p3_oe, p5_oe, p3_pu} == 25'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    c_irq: cover property (ext_irq_inputs[0]);
    c_ana: cover property (go && ctrl_mode_p6 ##1 analog_inputs != 8'h00);
    c_tmr: cover property (go && ctrl_mode_p2[P2_TO] && timer_a_out);
endmodule
bind mpc_top mpc_monitor i_mon (.*);
`default_nettype wire

// ### tb/mpc_board.sv
// board model: resolves each pin from drivers, pull-ups and floating lines
`timescale 1ns/1ps
`default_nettype none
module mpc_board (
    input  wire logic        clock,
    input  wire logic [22:0] drv_out,
    input  wire logic [22:0] drv_oe,
    input  wire logic [22:0] pu,
    input  wire logic [22:0] ext_val,
    input  wire logic [22:0] ext_en,
    output logic      [22:0] pin
);
    logic tgl_ff = 1'b0;
    // a floating line wanders, so a stale level never passes for a driven one
    // plain always: the declaration already gives the start value
    always @(posedge clock) begin
        tgl_ff <= ~tgl_ff;
    end
    always_comb begin
        for (int i = 0; i < 23; i++) begin
            if (drv_oe[i]) pin[i] = drv_out[i];
            else if (ext_en[i]) pin[i] = ext_val[i];
            else pin[i] = pu[i] | tgl_ff;
        end
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the multiport pin control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [5:0] d0;
        logic [7:0] pus;
        logic [6:0] d2, l2, u2;
        logic [5:0] e_oe0, e_pu0;
        logic [6:0] e_oe2, e_pu2;
    } mpc_row_s;
    logic clock, rst_n, clk_en, ctrl_mode_p6, analog_en, timer_a_out, timer_b_out, timer_c_out;
    logic wide_timer_out, buzzer_out, buzzer_sel, sync_serial_out, async_tx, async_sel;
    logic sync_serial_clock_out, timer_a_clock_in, timer_b_clock_in, capture_edge_in;
    logic sync_serial_in, sync_serial_clock, serial_chip_select, async_rx, async_clock_in;
    logic [1:0] direction_reg_p1, out_latch_p1, p1_in, p1_out, p1_oe, p1_pu, rd_p1;
    logic [3:0] direction_reg_p3, direction_reg_p5, pullup_sel_p3, ctrl_mode_p3, out_latch_p3;
    logic [3:0] out_latch_p5, p3_in, p3_out, p3_oe, p3_pu, p5_in, p5_out, p5_oe, rd_p3, rd_p5;
    logic [3:0] ext_irq_inputs;
    logic [5:0] direction_reg_p0, out_latch_p0, p0_in, p0_out, p0_oe, p0_pu, rd_p0;
    logic [6:0] direction_reg_p2, pullup_sel_p2, ctrl_mode_p2, out_latch_p2, p2_in, p2_out;
    logic [6:0] p2_oe, p2_pu, rd_p2;
    logic [7:0] pullup_sel_low_ports, edge_sel, p6_in, rd_p6, analog_inputs, n_r, n_f;
    logic [9:0] per;
    logic [22:0] ev, ee, pins;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    mpc_row_s rows [4] = '{
        '{6'h3F, 8'hFF, 7'h7F, 7'h00, 7'h7F, 6'h00, 6'h3F, 7'h00, 7'h67},
        '{6'h00, 8'hFF, 7'h00, 7'h7F, 7'h7F, 6'h3F, 6'h00, 7'h67, 7'h67},
        '{6'h2A, 8'h0F, 7'h00, 7'h00, 7'h05, 6'h15, 6'h0A, 7'h7F, 7'h05},
        '{6'h15, 8'h3F, 7'h55, 7'h18, 7'h18, 6'h2A, 6'h15, 7'h22, 7'h00}};
    assign {timer_a_out, timer_b_out, timer_c_out, wide_timer_out, buzzer_out, buzzer_sel,
            sync_serial_out, async_tx, async_sel, sync_serial_clock_out} = per;
    assign {p5_in, p3_in, p2_in, p1_in, p0_in} = pins;
    mpc_top i_dut (.*);
    // open-drain lines carry a board resistor
    mpc_board i_brd (.clock(clock), .drv_out({p5_out, p3_out, p2_out, p1_out, p0_out}),
        .drv_oe({p5_oe, p3_oe, p2_oe, p1_oe, p0_oe}),
        .pu({4'hF, p3_pu, p2_pu | 7'h18, p1_pu, p0_pu}), .ext_val(ev), .ext_en(ee), .pin(pins));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        {rst_n, ctrl_mode_p6, per, ctrl_mode_p2, ctrl_mode_p3, edge_sel, ev} = '0;
        {direction_reg_p0, pullup_sel_low_ports, pullup_sel_p2, pullup_sel_p3} = {6'h00, 19'h7FFFF};
        {direction_reg_p1, direction_reg_p2, direction_reg_p3, direction_reg_p5} = '1;
        {out_latch_p0, out_latch_p1, out_latch_p2, out_latch_p3, out_latch_p5} = '1;
        clk_en = 1'b1;
        p6_in = 8'h00;
        ee = 23'h07FFFF;
        tick(12);
        chk("reset oe", 8'h00, {2'h0, p0_oe});
        chk("reset pu", 8'h00, {1'b0, p2_pu});
        rst_n = 1'b1;
        foreach (rows[i]) begin
            {direction_reg_p0, pullup_sel_low_ports} = {rows[i].d0, rows[i].pus};
            {direction_reg_p1, direction_reg_p3} = {rows[i].d0[1:0], rows[i].d0[3:0]};
            {direction_reg_p2, out_latch_p2, pullup_sel_p2} = {rows[i].d2, rows[i].l2, rows[i].u2};
            pullup_sel_p3 = rows[i].u2[3:0];
            tick(2);
            chk("p0_oe", 8'(rows[i].e_oe0), 8'(p0_oe));
            chk("p0_pu", 8'(rows[i].e_pu0), 8'(p0_pu));
            chk("p1_oe", {6'h00, ~rows[i].d0[1:0]}, 8'(p1_oe));
            chk("p1_pu", {6'h00, rows[i].d0[1:0] & rows[i].pus[7:6]}, 8'(p1_pu));
            chk("p0_out", 8'h3F, 8'(p0_out));
            chk("p2_oe", 8'(rows[i].e_oe2), 8'(p2_oe));
            chk("p2_pu", 8'(rows[i].e_pu2), 8'(p2_pu));
            chk("p3_oe", {4'h0, ~rows[i].d0[3:0]}, 8'(p3_oe));
            chk("p3_pu", 8'(rows[i].u2[3:0]), 8'(p3_pu));
        end
        direction_reg_p3 = 4'hF;
        // last pass keeps both edges selected but the pin out of control mode
        for (int m = 0; m < 5; m++) begin
            edge_sel = (m == 4) ? 8'h03 : 8'(m);
            ctrl_mode_p3 = (m == 4) ? 4'h0 : 4'h1;
            {n_r, n_f} = '0;
            ev[15] = 1'b1;
            repeat (12) begin tick(1); n_r += 8'(ext_irq_inputs[0]); end
            ev[15] = 1'b0;
            repeat (12) begin tick(1); n_f += 8'(ext_irq_inputs[0]); end
            chk("irq rise", (m == 4) ? 8'h00 : 8'(m % 2), n_r);
            chk("irq fall", (m == 4) ? 8'h00 : 8'(m / 2), n_f);
        end
        ev[15] = 1'b1;
        tick(8);
        chk("capture in off", 8'h00, 8'(capture_edge_in));
        ctrl_mode_p3 = 4'h1;
        tick(2);
        chk("capture in", 8'h01, 8'(capture_edge_in));
        chk("timer b in", 8'h01, 8'(timer_b_clock_in));
        {ctrl_mode_p2, direction_reg_p2, per} = {7'h44, 7'h04, 10'h200};
        ev[10] = 1'b1;
        tick(8);
        chk("async rx", 8'h03, {6'h0, async_rx, sync_serial_in});
        chk("timer a pin", 8'h01, 8'(p2_out[6]));
        {ctrl_mode_p2, per} = {7'h00, 10'h000};
        tick(2);
        chk("async rx off", 8'h00, 8'(async_rx));
        p6_in = 8'hA5;
        tick(8);
        chk("rd_p6", 8'hA5, rd_p6);
        ctrl_mode_p6 = 1'b1;
        tick(8);
        chk("analog", 8'hA5, analog_inputs);
        chk("rd_p6 analog", 8'h00, rd_p6);
        chk("analog_en", 8'h01, 8'(analog_en));
        {direction_reg_p5, out_latch_p5} = {4'h0, 4'h5};
        tick(8);
        chk("p5_oe", 8'h0A, 8'(p5_oe));
        chk("rd_p5", 8'h05, 8'(rd_p5));
        // enable low must freeze the drivers
        clk_en = 1'b0;
        direction_reg_p0 = 6'h3F;
        tick(2);
        chk("p0_oe frozen", 8'h2A, 8'(p0_oe));
        clk_en = 1'b1;
        tick(2);
        chk("p0_oe resumed", 8'h00, 8'(p0_oe));
        // reset again in mid-run
        direction_reg_p0 = 6'h00;
        tick(2);
        rst_n = 1'b0;
        tick(2);
        chk("rerun oe", 8'h00, 8'(p0_oe));
        chk("rerun pu", 8'h00, 8'(p3_pu));
        rst_n = 1'b1;
        tick(2);
        chk("after rerun oe", 8'h3F, 8'(p0_oe));
        summarize();
    end
endmodule
`default_nettype wire
